// *** servo_seq_top.sv ***
// Purpose: override selection and servo-on sequencing of a servo amplifier
// Assumes: 10 MHz clock, pins are asynchronous and are synchronised here
// Notes: registers on classic wishbone, 32-bit data
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module servo_seq_top
  import servo_seq_pkg::*;
#(
  parameter int unsigned POWERUP_CNT = POWERUP_CYCLES,
  parameter int unsigned READY_CNT = READY_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_override_select,
  input wire logic i_servo_on_request,
  input wire logic i_fault_clear_input,
  input wire logic i_mode_button,
  input wire logic signed [15:0] i_override_voltage_input,
  input wire logic i_alarm,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic i_wb_we,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_base_enable,
  output logic o_ready,
  output logic o_alarm,
  output logic [15:0] o_speed
);
  // pin synchronisers, two stages each
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic mode_btn_last;
  // override word is held steady by the converter, so two flops suffice
  logic signed [15:0] volt_meta;
  logic signed [15:0] volt_sync;
  // registers
  logic [2:0] op_mode;
  logic signed [15:0] override_offset_param;
  logic [15:0] speed_cmd;
  logic [3:0] disp_mode;
  logic [31:0] rd_data;
  logic ack;
  logic [2:0] next_op_mode;
  logic signed [15:0] next_offset;
  logic [15:0] next_speed_cmd;
  logic [3:0] next_disp_mode;
  logic [31:0] next_rd_data;
  logic next_ack;
  // sequencer
  seq_state_t state;
  seq_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic override_allowed;

  logic ovr_sel_s;
  logic son_s;
  logic res_s;
  logic btn_s;
  logic alarm_s;
  assign ovr_sel_s = pin_sync[0];
  assign son_s = pin_sync[1];
  assign res_s = pin_sync[2];
  assign btn_s = pin_sync[3];
  assign alarm_s = pin_sync[4];

  // clamp a written offset into its legal span
  function automatic logic signed [15:0] clamp_offset(input logic signed [15:0] v);
    if (v > OFFSET_MAX) begin
      clamp_offset = OFFSET_MAX;
    end else if (v < OFFSET_MIN) begin
      clamp_offset = OFFSET_MIN;
    end else begin
      clamp_offset = v;
    end
  endfunction : clamp_offset

  ////////////////////////////////////////////////////////////////////
  // input synchronisers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      volt_meta <= 16'h0000;
      volt_sync <= 16'h0000;
      mode_btn_last <= 1'b0;
    end else begin
      pin_meta <= {i_alarm, i_mode_button, i_fault_clear_input, i_servo_on_request, i_override_select};
      pin_sync <= pin_meta;
      volt_meta <= i_override_voltage_input;
      volt_sync <= volt_meta;
      mode_btn_last <= btn_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wishbone register file and display mode
  always_comb begin
    next_op_mode = op_mode;
    next_offset = override_offset_param;
    next_speed_cmd = speed_cmd;
    next_disp_mode = disp_mode;
    next_rd_data = rd_data;
    next_ack = 1'b0;
    if (btn_s && !mode_btn_last) begin
      next_disp_mode = (disp_mode == DISP_MODES - 4'h1) ? 4'h0 : disp_mode + 4'h1;
    end
    if (i_wb_cyc && i_wb_stb && !ack) begin
      next_ack = 1'b1;
      next_rd_data = 32'h00000000;
      if (i_wb_adr == ADDR_CTRL) begin
        if (i_wb_we && i_wb_sel[0]) begin
          next_op_mode = i_wb_dat[CTRL_MODE_LSB +: 3];
        end
        next_rd_data[CTRL_MODE_LSB +: 3] = op_mode;
        next_rd_data[CTRL_DISP_LSB +: 4] = disp_mode;
      end else if (i_wb_adr == ADDR_OFFSET) begin
        if (i_wb_we && i_wb_sel[1:0] == 2'b11) begin
          next_offset = clamp_offset(i_wb_dat[15:0]);
        end
        next_rd_data = 32'(override_offset_param);
      end else if (i_wb_adr == ADDR_SPEED_CMD) begin
        if (i_wb_we && i_wb_sel[1:0] == 2'b11) begin
          next_speed_cmd = i_wb_dat[15:0];
        end
        next_rd_data = {16'h0000, speed_cmd};
      end else if (i_wb_adr == ADDR_STATUS) begin
        next_rd_data[ST_ACCEPT] = (state != SEQ_WAIT_POWER);
        next_rd_data[ST_BASE] = o_base_enable;
        next_rd_data[ST_READY] = o_ready;
      end else if (i_wb_adr == ADDR_SPEED_OUT) begin
        next_rd_data = {16'h0000, o_speed};
      end else if (i_wb_adr == ADDR_OVR_IN) begin
        next_rd_data = 32'(volt_sync);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_mode <= 3'h0;
      override_offset_param <= 16'sh0000;
      speed_cmd <= 16'h0000;
      disp_mode <= 4'h0;
      rd_data <= 32'h00000000;
      ack <= 1'b0;
    end else begin
      op_mode <= next_op_mode;
      override_offset_param <= next_offset;
      speed_cmd <= next_speed_cmd;
      disp_mode <= next_disp_mode;
      rd_data <= next_rd_data;
      ack <= next_ack;
    end
  end

  assign o_wb_dat = rd_data;
  assign o_wb_ack = ack;

  ////////////////////////////////////////////////////////////////////
  // power-up delay, servo-on, base circuit and ready sequencing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      SEQ_WAIT_POWER: begin
        // servo-on held back until the delay ends
        if (cnt >= POWERUP_CNT - 1) begin
          next_state = SEQ_IDLE;
          next_cnt = 32'h00000000;
        end else begin
          next_cnt = cnt + 32'h00000001;
        end
      end
      SEQ_IDLE: begin
        if (son_s && !res_s) begin
          next_state = SEQ_BASE_ON;
          next_cnt = 32'h00000000;
        end
      end
      SEQ_BASE_ON: begin
        if (res_s || !son_s) begin
          next_state = SEQ_IDLE;
        end else if (cnt >= READY_CNT - 1) begin
          next_state = SEQ_READY;
        end else begin
          next_cnt = cnt + 32'h00000001;
        end
      end
      SEQ_READY: begin
        if (res_s || !son_s) begin
          next_state = SEQ_IDLE;
        end
      end
      default: begin
        next_state = SEQ_WAIT_POWER;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SEQ_WAIT_POWER;
      cnt <= 32'h00000000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // base drops combinationally on a synchronised fault clear
  assign o_base_enable = (state == SEQ_BASE_ON || state == SEQ_READY) && !res_s;
  assign o_ready = (state == SEQ_READY) && !res_s;
  assign o_alarm = alarm_s;

  ////////////////////////////////////////////////////////////////////
  // override permitted only in certain operating modes
  always_comb begin
    case (op_mode_t'(op_mode))
      MODE_AUTO, MODE_JOG, MODE_HOME_POS: override_allowed = 1'b1;
      default: override_allowed = 1'b0;
    endcase
  end

  speed_override u_speed_override (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_volt_mv(volt_sync),
    .i_offset_mv(override_offset_param),
    .i_apply(ovr_sel_s && override_allowed),
    .i_speed(speed_cmd),
    .o_speed(o_speed)
  );
endmodule : servo_seq_top

// *** servo_seq_pkg.sv ***
// Purpose: shared constants for override and servo-on sequencing
// Assumes: 10 MHz system clock
// Notes: register map lives on a classic wishbone slave
package servo_seq_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned POWERUP_DELAY_MS = 4500; // between 4 s and 5 s
  localparam int unsigned READY_DELAY_MS = 5;
  localparam int unsigned POWERUP_CYCLES = CLK_HZ / 1000 * POWERUP_DELAY_MS;
  localparam int unsigned READY_CYCLES = CLK_HZ / 1000 * READY_DELAY_MS;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_SPEED_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_SPEED_OUT = 8'h10;
  localparam logic [7:0] ADDR_OVR_IN = 8'h14;
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0; // operating mode, 3 bits
  localparam int CTRL_DISP_LSB = 4; // display mode, read only, 4 bits
  // status fields
  localparam int ST_ACCEPT = 0;
  localparam int ST_BASE = 1;
  localparam int ST_READY = 2;
  // limits
  localparam logic signed [15:0] OFFSET_MAX = 16'sh270f;
  localparam logic signed [15:0] OFFSET_MIN = -16'sh270f;
  localparam logic signed [15:0] VOLT_MAX_MV = 16'sh2710;
  localparam logic signed [15:0] VOLT_MIN_MV = -16'sh2710;
  localparam logic [3:0] DISP_MODES = 4'hc;
  typedef enum logic [2:0] {
    MODE_AUTO = 3'h0,
    MODE_JOG = 3'h1,
    MODE_HOME_POS = 3'h2,
    MODE_HANDWHEEL = 3'h3,
    MODE_HOME_RETURN = 3'h4,
    MODE_TEST = 3'h5
  } op_mode_t;
  typedef enum logic [1:0] {
    SEQ_WAIT_POWER = 2'b00,
    SEQ_IDLE = 2'b01,
    SEQ_BASE_ON = 2'b11,
    SEQ_READY = 2'b10
  } seq_state_t;
endpackage : servo_seq_pkg

// *** speed_override.sv ***
// Purpose: scales commanded speed by the analog override voltage
// Assumes: override voltage arrives as signed millivolts, same clock
// Notes: percent = 100 + v/100, clamped to 0..200
`timescale 1ns/1ns
module speed_override
  import servo_seq_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic signed [15:0] i_volt_mv,
  input wire logic signed [15:0] i_offset_mv,
  input wire logic i_apply,
  input wire logic [15:0] i_speed,
  output logic [15:0] o_speed
);
  logic signed [17:0] sum_mv;
  logic signed [15:0] clamp_mv;
  logic [31:0] scaled;
  logic [15:0] next_speed;

  ////////////////////////////////////////////////////////////////////
  // offset, clamp, linear map, select
  always_comb begin
    sum_mv = 18'(i_volt_mv) + 18'(i_offset_mv);
    if (sum_mv > 18'(VOLT_MAX_MV)) begin
      clamp_mv = VOLT_MAX_MV;
    end else if (sum_mv < 18'(VOLT_MIN_MV)) begin
      clamp_mv = VOLT_MIN_MV;
    end else begin
      clamp_mv = sum_mv[15:0];
    end
    // speed * (v + 10000) / 10000 : 0% .. 100% .. 200%
    scaled = 32'(i_speed) * 32'(16'(clamp_mv + VOLT_MAX_MV)) / 32'h00002710;
    // above full scale the result saturates instead of wrapping
    if (i_apply && scaled > 32'h0000ffff) begin
      next_speed = 16'hffff;
    end else if (i_apply) begin
      next_speed = scaled[15:0];
    end else begin
      next_speed = i_speed;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_speed <= 16'h0000;
    end else begin
      o_speed <= next_speed;
    end
  end
endmodule : speed_override

// *** servo_seq_sva.sv ***
// Purpose: port checks of servo_seq_top
// Assumes: counts come from the bound top
// Notes: bind at the foot
`timescale 1ns/1ns
module servo_seq_sva
  import servo_seq_pkg::*;
#(
  parameter int unsigned POWERUP_CNT = 50,
  parameter int unsigned READY_CNT = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_servo_on_request,
  input wire logic i_fault_clear_input,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic o_base_enable,
  input wire logic o_ready
);
  int unsigned up, wt, next_up, next_wt;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // cycles since reset, cycles base waits for ready
  always_comb begin
    next_up = (up < POWERUP_CNT + 9) ? up + 1 : up;
    next_wt = (o_base_enable && !o_ready) ? wt + 1 : 0;
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up <= 0;
      wt <= 0;
    end else begin
      up <= next_up;
      wt <= next_wt;
    end
  end
  a_base_held_off: assert property (o_base_enable |-> up > POWERUP_CNT) else $error("base early");
  a_base_granted: assert property ((i_servo_on_request && !i_fault_clear_input)[*5] ##0 up > POWERUP_CNT + 4
    |-> o_base_enable) else $error("base missing");
  a_ready_late: assert property (o_base_enable && !o_ready |-> wt < READY_CNT) else $error("ready late");
  a_ready_early: assert property ($rose(o_ready) |-> wt == READY_CNT) else $error("ready early");
  a_ready_base: assert property (o_ready |-> o_base_enable) else $error("ready without base");
  a_fault_drop: assert property (i_fault_clear_input[*2] |=> !o_base_enable && !o_ready) else $error("fault");
  a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_idle: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack) else $error("stray ack");
endmodule : servo_seq_sva
bind servo_seq_top servo_seq_sva #(.POWERUP_CNT(POWERUP_CNT), .READY_CNT(READY_CNT)) u_servo_seq_sva (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_servo_on_request(i_servo_on_request),
  .i_fault_clear_input(i_fault_clear_input), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .o_wb_ack(o_wb_ack), .o_base_enable(o_base_enable), .o_ready(o_ready));

// *** host_ctrl.sv ***
// Purpose: host controller model
// Assumes: bench gives commands
// Notes: alarm opens contactor
`timescale 1ns/1ns
module host_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_alarm,
  input wire logic i_son_cmd,
  input wire logic i_clr_cmd,
  output logic o_servo_on_request,
  output logic o_fault_clear_input,
  output logic o_contactor_on
);
  // pins follow commands; contactor opens for good
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_servo_on_request <= 1'b0;
      o_fault_clear_input <= 1'b0;
      o_contactor_on <= 1'b1;
    end else begin
      o_servo_on_request <= i_son_cmd;
      o_fault_clear_input <= i_clr_cmd;
      o_contactor_on <= o_contactor_on && !i_alarm;
    end
  end
endmodule : host_ctrl

// *** servo_seq_top_bench.sv ***
// Purpose: bench of servo_seq_top
// Assumes: short counts P and R
// Notes: host_ctrl drives the servo-on and fault clear pins; the bench drives the others
`timescale 1ns/1ns
module servo_seq_top_bench;
  import servo_seq_pkg::*;
  localparam int unsigned P = 50;
  localparam int unsigned R = 20;
  logic clk, rst_n, override_select, btn, alarm, we, cyc, stb, ack, base, rdy, alm, son_cmd, clr_cmd, servo_on_request, clr, cont;
  logic signed [15:0] volt;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [15:0] spd;
  logic [31:0] dat, rd, q;
  int checks = 0;
  int bad_count = 0;
  servo_seq_top #(.POWERUP_CNT(P), .READY_CNT(R)) u_servo_seq_top (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_override_select(override_select), .i_servo_on_request(servo_on_request), .i_fault_clear_input(clr), .i_mode_button(btn),
    .i_override_voltage_input(volt), .i_alarm(alarm), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel),
    .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rd), .o_wb_ack(ack),
    .o_base_enable(base), .o_ready(rdy), .o_alarm(alm), .o_speed(spd));
  host_ctrl u_host_ctrl (.i_sys_clk(clk), .i_rst_n(rst_n), .i_alarm(alm), .i_son_cmd(son_cmd),
    .i_clr_cmd(clr_cmd), .o_servo_on_request(servo_on_request), .o_fault_clear_input(clr), .o_contactor_on(cont));
  ////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      test_done();
    end
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic t_power;
    // pin is high from release: base comes one edge after the delay and the pin flops
    tick(P + 1);
    chk({31'h0, base}, 32'h0);
    tick(1);
    chk({30'h0, base, rdy}, 32'h2);
    tick(R - 1);
    chk({31'h0, rdy}, 32'h0);
    tick(1);
    chk({31'h0, rdy}, 32'h1);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h7);
  endtask : t_power
  task automatic t_fault;
    clr_cmd <= 1'b1;
    tick(5);
    chk({30'h0, base, rdy}, 32'h0);
    clr_cmd <= 1'b0;
    alarm <= 1'b1;
    tick(R + 10);
    chk({28'h0, base, rdy, alm, cont}, 32'he);
  endtask : t_fault
  task automatic t_case(input logic s, input logic [2:0] m, input logic [15:0] v, o, e);
    wb(1'b1, ADDR_CTRL, {29'h0, m});
    wb(1'b1, ADDR_OFFSET, {{16{o[15]}}, o});
    override_select <= s;
    volt <= v;
    tick(6);
    chk({16'h0, spd}, {16'h0, e});
  endtask : t_case
  task automatic t_override;
    wb(1'b1, ADDR_SPEED_CMD, 32'h3e8);
    // a write without both low byte lanes is ignored
    sel <= 4'h4;
    wb(1'b1, ADDR_SPEED_CMD, 32'h1234);
    sel <= 4'hf;
    wb(1'b0, ADDR_SPEED_CMD, 32'h0);
    chk(q, 32'h3e8);
    t_case(1'b0, 3'h0, 16'h1388, 16'h0, 16'h3e8);
    t_case(1'b1, 3'h0, 16'h2710, 16'h0, 16'h7d0);
    wb(1'b0, ADDR_SPEED_OUT, 32'h0);
    chk(q, 32'h7d0);
    t_case(1'b1, 3'h0, 16'hd8f0, 16'h0, 16'h0);
    wb(1'b0, ADDR_OVR_IN, 32'h0);
    chk(q, 32'hffffd8f0);
    t_case(1'b1, 3'h0, 16'h0, 16'h1388, 16'h5dc);
    for (logic [3:0] m = 4'h0; m < 4'h6; m++) t_case(1'b1, m[2:0], 16'h1388, 16'h0, m < 4'h3 ? 16'h5dc : 16'h3e8);
    wb(1'b1, ADDR_OFFSET, 32'hffffd120);
    wb(1'b0, ADDR_OFFSET, 32'h0);
    chk(q, 32'hffffd8f1);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    // full-scale command at 200% saturates
    wb(1'b1, ADDR_SPEED_CMD, 32'hffff);
    t_case(1'b1, 3'h0, 16'h2710, 16'h0, 16'hffff);
  endtask : t_override
  task automatic t_display;
    for (logic [4:0] i = 5'h1; i < 5'he; i++) begin
      btn <= 1'b1;
      tick(4);
      btn <= 1'b0;
      tick(4);
      wb(1'b0, ADDR_CTRL, 32'h0);
      chk({28'h0, q[7:4]}, i > 5'hb ? i - 5'hc : {27'h0, i});
    end
  endtask : t_display
  // reset, then scenarios
  initial begin
    {rst_n, override_select, btn, alarm, we, cyc, stb, clr_cmd, volt, adr, dat} = '0;
    son_cmd = 1'b1;
    sel = 4'hf;
    tick(16);
    rst_n <= 1'b1;
    t_power();
    t_override();
    t_display();
    t_fault();
    test_done();
  end
endmodule : servo_seq_top_bench
